// ### port_strap_default_config.sv
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
// What this block does
// - Negotiation strap sets negotiation enable reset value
// - Negotiation strap shapes rate, duplex, advertise, mode
// - Speed strap shapes rate, 10M advertise, mode
// - Duplex strap shapes duplex, 10M full, mode
// - Backpressure strap sets port 2 backpressure default
// - Pause strap sets transmit/receive pause, asymmetric
// - Manual pause strap sets select, pause advertisement
// - Port 0 speed strap shapes partner ability bits
// - Failed virtual negotiation uses port 0 speed strap
// - Polarity strap inverts port 0 duplex pin
// - Polarity strap shapes partner duplex ability bits
// - Loader values replace soft straps, pins otherwise
module port_strap_default_config #(
    parameter int STRAP_COUNT = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [STRAP_COUNT-1:0] strapPins,
    input wire logic [STRAP_COUNT-1:0] loaderValue,
    input wire logic [STRAP_COUNT-1:0] loaderValid,
    input wire logic loaderDone,
    input wire logic macMode,
    input wire logic port0_twoway_input_pin,
    input wire logic virtualNegFailed,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic [2:0] phy_basic_ctrl_reg,
    output logic [3:0] phy_advertise_reg,
    output logic [2:0] phy_special_modes_reg,
    output logic [3:0] port2FlowCtrl,
    output logic [3:0] virtual_partner_ability_reg,
    output logic port0FullDuplex,
    output logic port0Speed100,
    output logic configLoaded
);

    logic rstSync1;
    logic rstSync2;
    logic [STRAP_COUNT-1:0] pinSync1;
    logic [STRAP_COUNT-1:0] pinSync2;
    logic duplexSync1;
    logic duplexSync2;
    logic [STRAP_COUNT-1:0] strapVal;
    logic [STRAP_COUNT-1:0] swOverride;
    logic [STRAP_COUNT-1:0] swValue;
    logic [STRAP_COUNT-1:0] effective;
    logic applyPending;
    logic apply;
    logic [2:0] next_ctrl;
    logic [3:0] next_adv;
    logic [2:0] next_mode;
    logic [3:0] next_flow;
    logic [3:0] next_partner;

    // The reset is released through two flops so that all state except swOverride and swValue leaves reset together.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end
        else
        begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end

    always_ff @(posedge clk or negedge rstSync2)
    begin
        if (!rstSync2)
        begin
            pinSync1 <= '0;
            pinSync2 <= '0;
            duplexSync1 <= 1'b0;
            duplexSync2 <= 1'b0;
        end
        else
        begin
            pinSync1 <= strapPins;
            pinSync2 <= pinSync1;
            duplexSync1 <= port0_twoway_input_pin;
            duplexSync2 <= duplexSync1;
        end
    end

    // Each soft strap is taken from the loader where it supplies one, else from its pin.
    generate
        for (genvar i = 0; i < STRAP_COUNT; i++)
        begin : g_strap
            assign effective[i] = loaderValid[i] ? loaderValue[i] : pinSync2[i];
        end
    endgenerate

    // Straps are captured after release, never under the asynchronous reset itself.
    always_ff @(posedge clk or negedge rstSync2)
    begin
        if (!rstSync2)
        begin
            applyPending <= 1'b1;
            configLoaded <= 1'b0;
        end
        else if (applyPending && loaderDone)
        begin
            applyPending <= 1'b0;
            configLoaded <= 1'b1;
        end
    end

    assign apply = applyPending && loaderDone;

    always_ff @(posedge clk or negedge rstSync2)
    begin
        if (!rstSync2)
        begin
            strapVal <= {strap_pkg::DEF_DUPLEX_POL0, strap_pkg::DEF_SPEED0,
                strap_pkg::DEF_PAUSE_MANUAL, strap_pkg::DEF_PAUSE_ENABLE,
                strap_pkg::DEF_BACKPRESSURE, strap_pkg::DEF_DUPLEX2,
                strap_pkg::DEF_SPEED2, strap_pkg::DEF_NEGOTIATE};
        end
        else if (apply)
        begin
            strapVal <= effective;
        end
    end

    // Derived defaults from the effective strap vector, loaded on apply.
    always_comb
    begin
        logic neg;
        logic spd;
        logic dup;
        neg = effective[strap_pkg::SB_NEGOTIATE];
        spd = effective[strap_pkg::SB_SPEED2];
        dup = effective[strap_pkg::SB_DUPLEX2];
        next_ctrl = '0;
        next_ctrl[strap_pkg::CTRL_NEGOTIATE] = neg;
        // With negotiation on, the forced bits keep the full-capability default.
        next_ctrl[strap_pkg::CTRL_RATE] = neg | spd;
        next_ctrl[strap_pkg::CTRL_TWOWAY] = neg | dup;
        next_adv = '0;
        next_adv[strap_pkg::ADV_10HALF] = neg | !spd;
        next_adv[strap_pkg::ADV_10FULL] = neg | (!spd && dup);
        next_adv[strap_pkg::ADV_SYM] = effective[strap_pkg::SB_PAUSE_MANUAL] ?
            1'b0 : effective[strap_pkg::SB_PAUSE_ENABLE];
        next_adv[strap_pkg::ADV_ASYM] = effective[strap_pkg::SB_PAUSE_MANUAL] ?
            1'b0 : effective[strap_pkg::SB_PAUSE_ENABLE];
        next_mode = neg ? strap_pkg::MODE_ALL_CAPABLE : {1'b0, spd, dup};
        next_flow = '0;
        next_flow[strap_pkg::FLOW_BP] = effective[strap_pkg::SB_BACKPRESSURE];
        next_flow[strap_pkg::FLOW_TX] = effective[strap_pkg::SB_PAUSE_ENABLE];
        next_flow[strap_pkg::FLOW_RX] = effective[strap_pkg::SB_PAUSE_ENABLE];
        next_flow[strap_pkg::FLOW_MANUAL] = effective[strap_pkg::SB_PAUSE_MANUAL];
        next_partner = '0;
        next_partner[strap_pkg::LP_100FULL] = effective[strap_pkg::SB_SPEED0] &
            !effective[strap_pkg::SB_DUPLEX_POL0];
        next_partner[strap_pkg::LP_100HALF] = effective[strap_pkg::SB_SPEED0];
        next_partner[strap_pkg::LP_10FULL] = !effective[strap_pkg::SB_SPEED0] &
            !effective[strap_pkg::SB_DUPLEX_POL0];
        next_partner[strap_pkg::LP_10HALF] = !effective[strap_pkg::SB_SPEED0];
    end

    // Target bits load their strap defaults once, then belong to software.
    always_ff @(posedge clk or negedge rstSync2)
    begin
        if (!rstSync2)
        begin
            phy_basic_ctrl_reg <= '0;
            phy_advertise_reg <= '0;
            phy_special_modes_reg <= '0;
            port2FlowCtrl <= '0;
            virtual_partner_ability_reg <= '0;
        end
        else if (apply)
        begin
            phy_basic_ctrl_reg <= next_ctrl;
            phy_advertise_reg <= next_adv;
            phy_special_modes_reg <= next_mode;
            port2FlowCtrl <= next_flow;
            virtual_partner_ability_reg <= next_partner;
        end
        else if (wr)
        begin
            case (addr)
                strap_pkg::OFS_PORT2_CTRL: phy_basic_ctrl_reg <= wdata[2:0];
                strap_pkg::OFS_PORT2_ADV: phy_advertise_reg <= wdata[3:0];
                strap_pkg::OFS_PORT2_MODE: phy_special_modes_reg <= wdata[2:0];
                strap_pkg::OFS_PORT2_FLOW: port2FlowCtrl <= wdata[3:0];
                strap_pkg::OFS_PARTNER: virtual_partner_ability_reg <= wdata[3:0];
                default: ;
            endcase
        end
    end

    // Software override and value registers are cleared by arst_n and only read back; they do not feed the strap mux.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            swOverride <= '0;
            swValue <= '0;
        end
        else if (wr && addr == strap_pkg::OFS_STRAP_OVERRIDE)
        begin
            swOverride <= wdata[STRAP_COUNT-1:0];
        end
        else if (wr && addr == strap_pkg::OFS_STRAP_VALUE)
        begin
            swValue <= wdata[STRAP_COUNT-1:0];
        end
    end

    // Port 0 run-time behaviour.
    always_ff @(posedge clk or negedge rstSync2)
    begin
        if (!rstSync2)
        begin
            port0FullDuplex <= 1'b0;
            port0Speed100 <= 1'b0;
        end
        else
        begin
            // A low-active duplex pin is inverted so that high always means full duplex.
            port0FullDuplex <= macMode ?
                (duplexSync2 ^ strapVal[strap_pkg::SB_DUPLEX_POL0]) :
                virtual_partner_ability_reg[strap_pkg::LP_100FULL];
            if (virtualNegFailed)
            begin
                port0Speed100 <= strapVal[strap_pkg::SB_SPEED0];
            end
            else
            begin
                port0Speed100 <= virtual_partner_ability_reg[strap_pkg::LP_100FULL] |
                    virtual_partner_ability_reg[strap_pkg::LP_100HALF];
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync2)
    begin
        if (!rstSync2)
        begin
            rdata <= '0;
        end
        else if (rd)
        begin
            case (addr)
                strap_pkg::OFS_STRAP_OVERRIDE: rdata <= {24'h0, swOverride};
                strap_pkg::OFS_STRAP_VALUE: rdata <= {24'h0, swValue};
                strap_pkg::OFS_PORT2_CTRL: rdata <= {29'h0, phy_basic_ctrl_reg};
                strap_pkg::OFS_PORT2_ADV: rdata <= {28'h0, phy_advertise_reg};
                strap_pkg::OFS_PORT2_MODE: rdata <= {29'h0, phy_special_modes_reg};
                strap_pkg::OFS_PORT2_FLOW: rdata <= {28'h0, port2FlowCtrl};
                strap_pkg::OFS_PARTNER: rdata <= {28'h0, virtual_partner_ability_reg};
                strap_pkg::OFS_PORT0_STATUS: rdata <= {29'h0, configLoaded,
                    port0Speed100, port0FullDuplex};
                strap_pkg::OFS_STRAP_LATCHED: rdata <= {24'h0, strapVal};
                default: rdata <= strap_pkg::READ_UNMAPPED;
            endcase
        end
        else
        begin
            rdata <= '0;
        end
    end

    property p_negotiate;
        @(posedge clk) disable iff (!rstSync2)
        apply |=> phy_basic_ctrl_reg[0] == $past(effective[0]);
    endproperty
    a_negotiate: assert property (p_negotiate) else $error("negotiation default wrong");

    property p_mode;
        @(posedge clk) disable iff (!rstSync2)
        apply && effective[0] |=> phy_special_modes_reg == 3'h7;
    endproperty
    a_mode: assert property (p_mode) else $error("mode default wrong");

    property p_rate;
        @(posedge clk) disable iff (!rstSync2)
        apply && !effective[0] |=> phy_basic_ctrl_reg[1] == $past(effective[1]);
    endproperty
    a_rate: assert property (p_rate) else $error("rate default wrong");

    property p_duplex;
        @(posedge clk) disable iff (!rstSync2)
        apply && !effective[0] |=> phy_basic_ctrl_reg[2] == $past(effective[2]);
    endproperty
    a_duplex: assert property (p_duplex) else $error("duplex default wrong");

    property p_bp;
        @(posedge clk) disable iff (!rstSync2)
        apply |=> port2FlowCtrl[0] == $past(effective[3]);
    endproperty
    a_bp: assert property (p_bp) else $error("backpressure default wrong");

    property p_pause;
        @(posedge clk) disable iff (!rstSync2)
        apply |=> port2FlowCtrl[1] == port2FlowCtrl[2] && port2FlowCtrl[1] == $past(effective[4]);
    endproperty
    a_pause: assert property (p_pause) else $error("pause default wrong");

    property p_manual;
        @(posedge clk) disable iff (!rstSync2)
        apply && effective[5] |=> port2FlowCtrl[3] && phy_advertise_reg[3:2] == 2'h0;
    endproperty
    a_manual: assert property (p_manual) else $error("manual pause default wrong");

    property p_partner;
        @(posedge clk) disable iff (!rstSync2)
        apply |=> virtual_partner_ability_reg[2] == $past(effective[6]);
    endproperty
    a_partner: assert property (p_partner) else $error("partner speed wrong");

    property p_fallback;
        @(posedge clk) disable iff (!rstSync2)
        virtualNegFailed |=> port0Speed100 == $past(strapVal[6]);
    endproperty
    a_fallback: assert property (p_fallback) else $error("fallback speed wrong");

    property p_polarity;
        @(posedge clk) disable iff (!rstSync2)
        macMode |=> port0FullDuplex == ($past(duplexSync2) ^ $past(strapVal[7]));
    endproperty
    a_polarity: assert property (p_polarity) else $error("duplex polarity wrong");

    property p_lp_full;
        @(posedge clk) disable iff (!rstSync2)
        apply |=> virtual_partner_ability_reg[3] == ($past(effective[6]) & !$past(effective[7]));
    endproperty
    a_lp_full: assert property (p_lp_full) else $error("partner full bit wrong");

    // The pin and loader copies are checked against a plain blend, not the mux itself.
    property p_loader;
        @(posedge clk) disable iff (!rstSync2)
        apply |=> strapVal == (($past(loaderValid) & $past(loaderValue)) |
            (~$past(loaderValid) & $past(pinSync2)));
    endproperty
    a_loader: assert property (p_loader) else $error("loader strap not taken");

    property p_sw_write;
        @(posedge clk) disable iff (!rstSync2)
        wr && !apply && addr == strap_pkg::OFS_PORT2_CTRL |=>
            phy_basic_ctrl_reg == $past(wdata[2:0]);
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("software write lost");

endmodule : port_strap_default_config

// ### strap_pkg.sv
package strap_pkg;

    // Reset values of the latched strap vector, held until the straps are applied.
    localparam logic DEF_NEGOTIATE = 1'h1;
    localparam logic DEF_SPEED2 = 1'h1;
    localparam logic DEF_DUPLEX2 = 1'h1;
    localparam logic DEF_BACKPRESSURE = 1'h1;
    localparam logic DEF_PAUSE_ENABLE = 1'h1;
    localparam logic DEF_PAUSE_MANUAL = 1'h0;
    localparam logic DEF_SPEED0 = 1'h1;
    localparam logic DEF_DUPLEX_POL0 = 1'h0;

    // Register offsets, word addressed on the plain register port.
    localparam logic [3:0] OFS_STRAP_OVERRIDE = 4'h0;
    localparam logic [3:0] OFS_STRAP_VALUE = 4'h1;
    localparam logic [3:0] OFS_PORT2_CTRL = 4'h2;
    localparam logic [3:0] OFS_PORT2_ADV = 4'h3;
    localparam logic [3:0] OFS_PORT2_MODE = 4'h4;
    localparam logic [3:0] OFS_PORT2_FLOW = 4'h5;
    localparam logic [3:0] OFS_PARTNER = 4'h6;
    localparam logic [3:0] OFS_PORT0_STATUS = 4'h7;
    localparam logic [3:0] OFS_STRAP_LATCHED = 4'h8;

    // Bit positions inside the strap vectors.
    localparam int SB_NEGOTIATE = 0;
    localparam int SB_SPEED2 = 1;
    localparam int SB_DUPLEX2 = 2;
    localparam int SB_BACKPRESSURE = 3;
    localparam int SB_PAUSE_ENABLE = 4;
    localparam int SB_PAUSE_MANUAL = 5;
    localparam int SB_SPEED0 = 6;
    localparam int SB_DUPLEX_POL0 = 7;

    // Control register fields.
    localparam int CTRL_NEGOTIATE = 0;
    localparam int CTRL_RATE = 1;
    localparam int CTRL_TWOWAY = 2;
    // Advertisement fields.
    localparam int ADV_10HALF = 0;
    localparam int ADV_10FULL = 1;
    localparam int ADV_SYM = 2;
    localparam int ADV_ASYM = 3;
    // Flow register fields.
    localparam int FLOW_BP = 0;
    localparam int FLOW_TX = 1;
    localparam int FLOW_RX = 2;
    localparam int FLOW_MANUAL = 3;
    // Partner ability fields.
    localparam int LP_10HALF = 0;
    localparam int LP_10FULL = 1;
    localparam int LP_100HALF = 2;
    localparam int LP_100FULL = 3;

    localparam logic [2:0] MODE_ALL_CAPABLE = 3'h7;
    localparam logic [31:0] READ_UNMAPPED = 32'h0;

endpackage : strap_pkg

// ### strap_source_model.sv
`timescale 1ns/1ps
module strap_source_model (
    input wire logic clk,
    input wire logic [7:0] boardPins,
    input wire logic [7:0] imageValue,
    input wire logic [7:0] imageValid,
    input wire logic startLoad,
    output logic [7:0] strapPins,
    output logic [7:0] loaderValue,
    output logic [7:0] loaderValid,
    output logic loaderDone
);
    logic [1:0] waitCnt;

    // Board straps are plain levels and follow the board setting.
    assign strapPins = boardPins;

    // The image is only offered once the loader has read it.
    // Until then the value lines carry the inverse so stale data cannot pass by luck.
    always_ff @(posedge clk)
    begin
        if (!startLoad)
        begin
            waitCnt <= 2'h0;
            loaderDone <= 1'h0;
            loaderValid <= 8'h0;
            loaderValue <= ~imageValue;
        end
        else if (waitCnt != 2'h3)
        begin
            waitCnt <= waitCnt + 2'h1;
        end
        else
        begin
            loaderValid <= imageValid;
            loaderValue <= imageValue;
            loaderDone <= 1'h1;
        end
    end
endmodule : strap_source_model

// ### port_strap_default_config_test.sv
`timescale 1ns/1ps
module port_strap_default_config_test;
    logic clk, arst_n, startLoad, macMode, duplexPin, negFailed, wr, rd, loaderDone;
    logic [7:0] boardPins, imgValue, imgValid, strapPins, loaderValue, loaderValid;
    logic [3:0] addr;
    logic [31:0] wdata, rdata;
    logic [2:0] ctrlOut, modeOut;
    logic [3:0] advOut, flowOut, partnerOut;
    logic fullDup, speed100, loaded;
    int errorCnt = 0;
    int numChecks = 0;

    strap_source_model partner (.clk(clk), .boardPins(boardPins), .imageValue(imgValue),
        .imageValid(imgValid), .startLoad(startLoad), .strapPins(strapPins),
        .loaderValue(loaderValue), .loaderValid(loaderValid), .loaderDone(loaderDone));

    port_strap_default_config #(.STRAP_COUNT(8)) dut (.clk(clk), .arst_n(arst_n),
        .strapPins(strapPins), .loaderValue(loaderValue), .loaderValid(loaderValid),
        .loaderDone(loaderDone), .macMode(macMode), .port0_twoway_input_pin(duplexPin),
        .virtualNegFailed(negFailed), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .phy_basic_ctrl_reg(ctrlOut), .phy_advertise_reg(advOut),
        .phy_special_modes_reg(modeOut), .port2FlowCtrl(flowOut),
        .virtual_partner_ability_reg(partnerOut), .port0FullDuplex(fullDup),
        .port0Speed100(speed100), .configLoaded(loaded));

    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    task automatic stopTest();
        $display("checks %0d errors %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stopTest

    // Generous bound: every trial needs fewer than ninety cycles.
    initial
    begin
        #400000;
        errorCnt++;
        stopTest();
    end

    task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp, input string what);
        numChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk_pin

    task automatic chk_reg(input logic [3:0] ofs, input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("unexpected at %0t: reg %h got %h want %h", $time, ofs, got, exp);
        end
    endtask : chk_reg

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'h1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'h0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        #1 v = rdata;
    endtask : rd_reg

    // Expected register contents worked out from the effective strap vector.
    function automatic logic [31:0] exp_reg(input int ofs, input logic [7:0] s);
        logic [3:0] lp;
        logic pa;
        lp = {s[6] & ~s[7], s[6], ~s[6] & ~s[7], ~s[6]};
        pa = s[4] & ~s[5];
        case (ofs)
            0, 1: return 32'h0;
            2: return {29'h0, s[0] | s[2], s[0] | s[1], s[0]};
            3: return {28'h0, pa, pa, s[0] | (~s[1] & s[2]), s[0] | ~s[1]};
            4: return {29'h0, s[0] ? strap_pkg::MODE_ALL_CAPABLE : {1'h0, s[1], s[2]}};
            5: return {28'h0, s[5], s[4], s[4], s[3]};
            6: return {28'h0, lp};
            7: return {29'h0, 1'h1, s[6], macMode ? duplexPin ^ s[7] : lp[3]};
            8: return {24'h0, s};
            default: return strap_pkg::READ_UNMAPPED;
        endcase
    endfunction : exp_reg

    task automatic run_trial(input logic [7:0] pins, input logic [7:0] val,
        input logic [7:0] vld, input logic mac);
        logic [7:0] s;
        logic [31:0] got;
        logic [3:0] pw;
        s = (vld & val) | (~vld & pins);
        pw = 4'(exp_reg(6, s)) ^ 4'hf;
        @(posedge clk);
        arst_n <= 1'h0;
        startLoad <= 1'h0;
        boardPins <= pins;
        imgValue <= val;
        imgValid <= vld;
        macMode <= mac;
        duplexPin <= 1'($urandom);
        repeat (8) @(posedge clk);
        arst_n <= 1'h1;
        repeat (6) @(posedge clk);
        #1 chk_pin({31'h0, loaded}, 32'h0, "loaded before apply");
        @(posedge clk);
        startLoad <= 1'h1;
        repeat (20)
        begin
            @(posedge clk);
            if (loaded === 1'h1)
                break;
        end
        #1 chk_pin({29'h0, ctrlOut}, exp_reg(2, s), "ctrl");
        chk_pin({28'h0, advOut}, exp_reg(3, s), "adv");
        chk_pin({29'h0, modeOut}, exp_reg(4, s), "mode");
        chk_pin({28'h0, flowOut}, exp_reg(5, s), "flow");
        chk_pin({28'h0, partnerOut}, exp_reg(6, s), "partner");
        chk_pin({29'h0, loaded, speed100, fullDup}, exp_reg(7, s), "status");
        for (int ofs = 0; ofs < 16; ofs++)
        begin
            rd_reg(4'(ofs), got);
            chk_reg(4'(ofs), got, exp_reg(ofs, s));
        end
        if (mac)
        begin
            for (int p = 0; p < 2; p++)
            begin
                @(posedge clk);
                duplexPin <= 1'(p);
                repeat (4) @(posedge clk);
                #1 chk_pin({31'h0, fullDup}, {31'h0, 1'(p) ^ s[7]}, "duplex pin");
            end
        end
        wr_reg(strap_pkg::OFS_PORT2_CTRL, exp_reg(2, s) ^ 32'h7);
        rd_reg(strap_pkg::OFS_PORT2_CTRL, got);
        chk_reg(strap_pkg::OFS_PORT2_CTRL, got, exp_reg(2, s) ^ 32'h7);
        chk_pin({29'h0, ctrlOut}, exp_reg(2, s) ^ 32'h7, "ctrl after write");
        wr_reg(strap_pkg::OFS_STRAP_OVERRIDE, {24'h0, vld});
        wr_reg(strap_pkg::OFS_STRAP_VALUE, {24'h0, val});
        rd_reg(strap_pkg::OFS_STRAP_OVERRIDE, got);
        chk_reg(strap_pkg::OFS_STRAP_OVERRIDE, got, {24'h0, vld});
        rd_reg(strap_pkg::OFS_STRAP_VALUE, got);
        chk_reg(strap_pkg::OFS_STRAP_VALUE, got, {24'h0, val});
        // A rewritten partner page must not move the speed while negotiation has failed.
        wr_reg(strap_pkg::OFS_PARTNER, {28'h0, pw});
        repeat (2) @(posedge clk);
        #1 chk_pin({30'h0, speed100, fullDup}, {30'h0, s[6], mac ? duplexPin ^ s[7] : pw[3]}, "partner written");
        @(posedge clk);
        negFailed <= 1'h0;
        repeat (2) @(posedge clk);
        #1 chk_pin({31'h0, speed100}, {31'h0, pw[3] | pw[2]}, "speed from partner");
        @(posedge clk);
        negFailed <= 1'h1;
        repeat (2) @(posedge clk);
        #1 chk_pin({31'h0, speed100}, {31'h0, s[6]}, "speed back to strap");
    endtask : run_trial

    initial
    begin
        arst_n = 1'h0;
        startLoad = 1'h0;
        macMode = 1'h0;
        duplexPin = 1'h0;
        negFailed = 1'h1;
        wr = 1'h0;
        rd = 1'h0;
        addr = 4'h0;
        wdata = 32'h0;
        boardPins = 8'h0;
        imgValue = 8'h0;
        imgValid = 8'h0;
        void'($urandom(80));
        run_trial({strap_pkg::DEF_DUPLEX_POL0, strap_pkg::DEF_SPEED0, strap_pkg::DEF_PAUSE_MANUAL,
            strap_pkg::DEF_PAUSE_ENABLE, strap_pkg::DEF_BACKPRESSURE, strap_pkg::DEF_DUPLEX2,
            strap_pkg::DEF_SPEED2, strap_pkg::DEF_NEGOTIATE}, 8'h0, 8'h0, 1'h0);
        run_trial(8'hff, 8'h00, 8'hff, 1'h1);
        run_trial(8'h00, 8'hff, 8'hff, 1'h1);
        run_trial(8'h00, 8'h00, 8'h00, 1'h0);
        for (int i = 0; i < 10; i++)
            run_trial(8'($urandom), 8'($urandom), 8'($urandom), 1'($urandom));
        stopTest();
    end
endmodule : port_strap_default_config_test
